// ### rtl/ptsr_pkg.sv
package ptsr_pkg;
    // Command words, first byte on the link is the low byte
    localparam logic [31:0] CMD_PROT = 32'h63657367;
    localparam logic [31:0] CMD_TRIG = 32'h696E7367;
    localparam int FRAME_BYTES = 28;
    localparam int BODY_BYTES = 26;
    localparam int CMD_BYTES = 4;
    // Protection flag bits
    localparam int PF_DRV_HOT = 0;
    localparam int PF_UV_CUT = 1;
    localparam int PF_BRIDGE = 2;
    localparam int PF_SWAP = 3;
    localparam int PF_LATCH = 4;
    localparam int PF_LINK = 5;
    localparam int PF_COIL = 6;
    localparam int PF_RESP = 7;
    // Trigger flag bits
    localparam int TF_ON = 0;
    localparam int TF_FALL = 1;
    localparam int TF_ABS = 2;
    // Register byte addresses
    localparam logic [7:0] A_LIMIT0 = 8'h00;
    localparam logic [7:0] A_LIMIT6 = 8'h18;
    localparam logic [7:0] A_PFLAGS = 8'h1C;
    localparam logic [7:0] A_TFLAGS = 8'h20;
    localparam logic [7:0] A_DEAD = 8'h24;
    localparam logic [7:0] A_POS = 8'h28;
    localparam logic [7:0] A_FPOS = 8'h2C;
    localparam logic [7:0] A_SPEED = 8'h30;
    localparam logic [7:0] A_FSPEED = 8'h34;
    localparam logic [7:0] A_STATUS = 8'h38;
    localparam int ST_BADCMD = 3;
    // Limit order: cutoff, I, V, T, usb I, usb V, usb min
    localparam int LIM_N = 7;
    localparam logic [15:0] LIM_MAX_RST = 16'hFFFF;
    localparam logic [15:0] LIM_MIN_RST = 16'h0000;
    // Timing
    localparam int CLK_NS = 10;
    localparam int US_NS = 1000;
    localparam int CLK_PER_US = US_NS / CLK_NS;
    // Checksum
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'hA001;

    typedef struct packed {
        logic [15:0] pwr_v;
        logic [15:0] pwr_i;
        logic [15:0] temp;
        logic [15:0] usb_i;
        logic [15:0] usb_v;
    } ptsr_meas_t;

    typedef struct packed {
        logic drv_hot;
        logic bridge;
        logic swap;
        logic coil;
        logic resp;
    } ptsr_fault_t;

    typedef struct packed {
        logic absolute;
        logic [31:0] pos;
        logic [15:0] fine;
        logic [31:0] speed;
        logic [7:0] fine_speed;
    } ptsr_move_t;

    typedef enum {ST_RX, ST_TX} ptsr_state_t;
endpackage

// ### rtl/ptsr_top.sv
`timescale 1ns/1ps
// Overview of operation
// - Four-byte word 0x63657367 is the protection-settings read command.
// - Protection reply: command, seven limits, flags, 7 zero bytes, checksum.
// - Any maximum exceeded or USB voltage below minimum raises alarm.
// - Driver overheat raises alarm when its flag is set.
// - Supply below cutoff turns motor off when its flag is set.
// - Bridge fault shuts power stage off when its flag is set.
// - Swapped travel borders raise alarm when its flag is set.
// - Latched mode holds alarms until a stop command clears them.
// - Link recovery function enabled exactly while its flag is set.
// - Winding mismatch raises alarm when its flag is set.
// - Bad motor response raises alarm when its flag is set.
// - Word 0x696E7367 reads trigger settings; 28-byte reply echoes command.
// - Trigger reply: flags, dead time, position, fine, speed, fine speed, zeros, checksum.
// - Trigger pulses act only while trigger enable is set.
// - Falling edge triggers when polarity flag set, rising otherwise.
// - Trigger moves absolute when flag set, relative otherwise.
// - Input is dead for the dead time in microseconds after a trigger.
// - Speed means steps per second for stepper, rpm for DC motor.
// - Fine fields used for stepper only, range set by step division.
module ptsr_top
    import ptsr_pkg::*;
#(
    parameter int CYC_PER_US = CLK_PER_US
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic [7:0] rx_data_i,
    input wire logic rx_valid_i,
    output logic [7:0] tx_data_o,
    output logic tx_valid_o,
    input wire logic tx_ready_i,
    input wire ptsr_meas_t meas_i,
    input wire ptsr_fault_t fault_i,
    input wire logic stop_i,
    input wire logic trig_pin_i,
    input wire logic stepper_i,
    input wire logic [2:0] step_division_setting_i,
    output logic alarm_o,
    output logic motor_off_o,
    output logic power_off_o,
    output logic link_recovery_enable_o,
    output logic move_start_o,
    output ptsr_move_t move_o
);
    // Dead-time counter is 23 bits: 65535 us times 128 still fits
    if (CYC_PER_US < 1 || CYC_PER_US > 128) begin : g_bad_cyc
        $error("CYC_PER_US out of range");
    end

    // ************************************************
    // Helpers
    // ************************************************
    function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int k = 0; k < 8; k++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    function automatic logic fine_ok(input logic [15:0] v, input logic [2:0] d);
        logic signed [16:0] lim;
        logic signed [16:0] sv;
        lim = 17'sh1 <<< d;
        sv = {v[15], v};
        return (sv < lim) && (sv > -lim);
    endfunction

    // ************************************************
    // Settings registers
    // ************************************************
    logic [15:0] limit_q [LIM_N];
    logic [7:0] pflags_q;
    logic [7:0] tflags_q;
    logic [15:0] trigger_deadtime_q;
    logic [31:0] pos_q;
    logic [15:0] fine_target_offset_q;
    logic [31:0] speed_q;
    logic [7:0] fine_target_rate_q;
    logic bad_cmd_q;
    logic bad_cmd_set;
    logic [22:0] dead_cnt_q;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            for (int k = 0; k < LIM_N; k++) begin
                limit_q[k] <= LIM_MAX_RST;
            end
            limit_q[0] <= LIM_MIN_RST;
            limit_q[LIM_N-1] <= LIM_MIN_RST;
            pflags_q <= 8'h00;
            tflags_q <= 8'h00;
            trigger_deadtime_q <= 16'h0000;
            pos_q <= 32'h0000_0000;
            fine_target_offset_q <= 16'h0000;
            speed_q <= 32'h0000_0000;
            fine_target_rate_q <= 8'h00;
        end else if (wr_i) begin
            if (addr_i <= A_LIMIT6 && addr_i[1:0] == 2'b00) begin
                limit_q[addr_i[4:2]] <= wdata_i[15:0];
            end
            case (addr_i)
                A_PFLAGS: pflags_q <= wdata_i[7:0];
                A_TFLAGS: tflags_q <= wdata_i[7:0];
                A_DEAD: trigger_deadtime_q <= wdata_i[15:0];
                A_POS: pos_q <= wdata_i;
                A_FPOS: fine_target_offset_q <= wdata_i[15:0];
                A_SPEED: speed_q <= wdata_i;
                A_FSPEED: fine_target_rate_q <= wdata_i[7:0];
                default: ;
            endcase
        end
    end

    // Set wins over write-one-to-clear
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            bad_cmd_q <= 1'b0;
        end else if (bad_cmd_set) begin
            bad_cmd_q <= 1'b1;
        end else if (wr_i && addr_i == A_STATUS && wdata_i[ST_BADCMD]) begin
            bad_cmd_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (rd_i) begin
            rdata_o <= 32'h0000_0000;
            if (addr_i <= A_LIMIT6 && addr_i[1:0] == 2'b00) begin
                rdata_o <= {16'h0000, limit_q[addr_i[4:2]]};
            end
            case (addr_i)
                A_PFLAGS: rdata_o <= {24'h000000, pflags_q};
                A_TFLAGS: rdata_o <= {24'h000000, tflags_q};
                A_DEAD: rdata_o <= {16'h0000, trigger_deadtime_q};
                A_POS: rdata_o <= pos_q;
                A_FPOS: rdata_o <= {16'h0000, fine_target_offset_q};
                A_SPEED: rdata_o <= speed_q;
                A_FSPEED: rdata_o <= {24'h000000, fine_target_rate_q};
                A_STATUS: rdata_o <= {27'h0, dead_cnt_q != 23'h0, bad_cmd_q,
                                      power_off_o, motor_off_o, alarm_o};
                default: ;
            endcase
        end
    end

    // ************************************************
    // Protection
    // ************************************************
    logic alarm_cause;
    always_comb begin
        alarm_cause = (meas_i.pwr_i > limit_q[1]) || (meas_i.pwr_v > limit_q[2])
            || (meas_i.temp > limit_q[3]) || (meas_i.usb_i > limit_q[4])
            || (meas_i.usb_v > limit_q[5]) || (meas_i.usb_v < limit_q[6]);
        alarm_cause = alarm_cause || (pflags_q[PF_DRV_HOT] && fault_i.drv_hot)
            || (pflags_q[PF_SWAP] && fault_i.swap)
            || (pflags_q[PF_COIL] && fault_i.coil)
            || (pflags_q[PF_RESP] && fault_i.resp);
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            alarm_o <= 1'b0;
        end else if (alarm_cause) begin
            alarm_o <= 1'b1;
        end else if (!pflags_q[PF_LATCH] || stop_i) begin
            alarm_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            motor_off_o <= 1'b0;
            power_off_o <= 1'b0;
            link_recovery_enable_o <= 1'b0;
        end else begin
            motor_off_o <= pflags_q[PF_UV_CUT] && (meas_i.pwr_v < limit_q[0]);
            power_off_o <= pflags_q[PF_BRIDGE] && fault_i.bridge;
            link_recovery_enable_o <= pflags_q[PF_LINK];
        end
    end

    // ************************************************
    // Command link
    // ************************************************
    ptsr_state_t state_q;
    logic [31:0] cmd_q;
    logic [1:0] rx_cnt_q;
    logic [4:0] idx_q;
    logic kind_q;
    logic [15:0] crc_q;
    logic [BODY_BYTES*8-1:0] frame_q;
    logic [31:0] cmd_full;
    logic rx_done;
    logic tx_go;
    logic [15:0] crc_nx;

    assign cmd_full = {rx_data_i, cmd_q[31:8]};
    assign rx_done = state_q == ST_RX && rx_valid_i && rx_cnt_q == 2'(CMD_BYTES - 1);
    assign tx_go = rx_done && (cmd_full == CMD_PROT || cmd_full == CMD_TRIG);
    assign bad_cmd_set = rx_done && !tx_go;
    assign crc_nx = crc_upd(crc_q, tx_data_o);

    // Bytes arriving during a reply are dropped
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cmd_q <= 32'h0000_0000;
            rx_cnt_q <= 2'b00;
        end else if (state_q == ST_RX && rx_valid_i) begin
            cmd_q <= cmd_full;
            rx_cnt_q <= rx_cnt_q + 2'b01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_q <= ST_RX;
            idx_q <= 5'h00;
            kind_q <= 1'b0;
            crc_q <= CRC_INIT;
            frame_q <= '0;
            tx_data_o <= 8'h00;
            tx_valid_o <= 1'b0;
        end else begin
            case (state_q)
                ST_RX: begin
                    if (tx_go) begin
                        state_q <= ST_TX;
                        idx_q <= 5'h00;
                        crc_q <= CRC_INIT;
                        tx_valid_o <= 1'b1;
                        tx_data_o <= cmd_full[7:0];
                        kind_q <= cmd_full == CMD_TRIG;
                        if (cmd_full == CMD_PROT) begin
                            frame_q <= {56'h0, pflags_q, limit_q[6], limit_q[5],
                                limit_q[4], limit_q[3], limit_q[2], limit_q[1],
                                limit_q[0], cmd_full};
                        end else begin
                            frame_q <= {64'h0, fine_target_rate_q, speed_q,
                                fine_target_offset_q, pos_q, trigger_deadtime_q,
                                tflags_q, cmd_full};
                        end
                    end
                end
                ST_TX: begin
                    if (tx_ready_i) begin
                        idx_q <= idx_q + 5'h01;
                        if (idx_q < 5'(BODY_BYTES)) begin
                            crc_q <= crc_nx;
                        end
                        if (idx_q < 5'(BODY_BYTES - 1)) begin
                            frame_q <= frame_q >> 8;
                            tx_data_o <= frame_q[15:8];
                        end else if (idx_q == 5'(BODY_BYTES - 1)) begin
                            tx_data_o <= crc_nx[7:0];
                        end else if (idx_q == 5'(BODY_BYTES)) begin
                            tx_data_o <= crc_q[15:8];
                        end else begin
                            tx_valid_o <= 1'b0;
                            tx_data_o <= 8'h00;
                            state_q <= ST_RX;
                        end
                    end
                end
                default: state_q <= ST_RX;
            endcase
        end
    end

    // ************************************************
    // Trigger input
    // ************************************************
    logic [2:0] sync_q;
    logic lvl_q;
    logic edge_hit;
    logic trig_take;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sync_q <= 3'b000;
            lvl_q <= 1'b0;
        end else begin
            sync_q <= {sync_q[1:0], trig_pin_i};
            if (sync_q[1] == sync_q[2]) begin
                lvl_q <= sync_q[2];
            end
        end
    end

    assign edge_hit = (sync_q[1] == sync_q[2]) && (lvl_q != sync_q[2])
        && (sync_q[2] == !tflags_q[TF_FALL]);
    assign trig_take = edge_hit && tflags_q[TF_ON] && dead_cnt_q == 23'h0;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            dead_cnt_q <= 23'h0;
        end else if (trig_take) begin
            dead_cnt_q <= 23'(trigger_deadtime_q * CYC_PER_US);
        end else if (dead_cnt_q != 23'h0) begin
            dead_cnt_q <= dead_cnt_q - 23'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            move_start_o <= 1'b0;
            move_o <= '0;
        end else begin
            move_start_o <= trig_take;
            if (trig_take) begin
                move_o.absolute <= tflags_q[TF_ABS];
                move_o.pos <= pos_q;
                move_o.speed <= speed_q;
                move_o.fine <= (stepper_i && fine_ok(fine_target_offset_q,
                    step_division_setting_i)) ? fine_target_offset_q : 16'h0000;
                move_o.fine_speed <= (stepper_i && fine_ok({8'h00, fine_target_rate_q},
                    step_division_setting_i)) ? fine_target_rate_q : 8'h00;
            end
        end
    end

    // ************************************************
    // Checks
    // ************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    chk_prot_start: assert property (rx_done && cmd_full == CMD_PROT
        |=> tx_valid_o && tx_data_o == CMD_PROT[7:0] && !kind_q)
        else $error("protection reply did not start");
    chk_trig_start: assert property (rx_done && cmd_full == CMD_TRIG
        |=> tx_valid_o && tx_data_o == CMD_TRIG[7:0] && kind_q)
        else $error("trigger reply did not start");
    chk_rsvd_zero: assert property (state_q == ST_TX && !kind_q && idx_q >= 5'h13
        && idx_q < 5'(BODY_BYTES) |-> tx_data_o == 8'h00)
        else $error("reserved byte not zero");
    chk_over_alarm: assert property (meas_i.pwr_v > limit_q[2] |=> alarm_o)
        else $error("overvoltage missed alarm");
    chk_hot_alarm: assert property (pflags_q[PF_DRV_HOT] && fault_i.drv_hot
        |=> alarm_o)
        else $error("driver heat missed alarm");
    chk_uv_off: assert property (pflags_q[PF_UV_CUT] && meas_i.pwr_v < limit_q[0]
        |=> motor_off_o)
        else $error("undervoltage did not cut motor");
    chk_bridge_off: assert property (pflags_q[PF_BRIDGE] && fault_i.bridge
        |=> power_off_o)
        else $error("bridge fault did not cut power");
    chk_latch_hold: assert property (pflags_q[PF_LATCH] && alarm_o && !stop_i
        && $stable(pflags_q) |=> alarm_o)
        else $error("latched alarm dropped");
    chk_trig_gate: assert property (!$past(tflags_q[TF_ON]) |-> !move_start_o)
        else $error("trigger acted while disabled");
    chk_dead_time: assert property (move_start_o && trigger_deadtime_q >= 16'h0008
        |-> ##1 !move_start_o [*8])
        else $error("trigger inside dead time");

    cov_prot: cover property (state_q == ST_TX && !kind_q && idx_q == 5'h1B && tx_ready_i);
    cov_trig: cover property (state_q == ST_TX && kind_q && idx_q == 5'h1B && tx_ready_i);
    cov_move: cover property (move_start_o && move_o.absolute);
    cov_dead_block: cover property (edge_hit && tflags_q[TF_ON] && dead_cnt_q != 23'h0);
endmodule

// ### tb/ptsr_host_model.sv
`timescale 1ns/1ps
// ************************************************
// Host side of the command link
// ************************************************
module ptsr_host_model (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic [31:0] cmd_i,
    input wire logic stall_i,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_valid_i,
    output logic [7:0] rx_data_o,
    output logic rx_valid_o,
    output logic tx_ready_o,
    output logic done_o,
    output int count_o
);
    logic [7:0] reply_q [28];

    initial begin : host_proc
        int w;
        rx_data_o = 8'h00;
        rx_valid_o = 1'b0;
        tx_ready_o = 1'b0;
        done_o = 1'b0;
        count_o = 0;
        forever begin
            @(posedge clk_i);
            if (go_i === 1'b1) begin
                done_o <= 1'b0;
                count_o = 0;
                // Request word, low byte first
                for (int i = 0; i < 4; i++) begin
                    rx_data_o <= cmd_i[8*i +: 8];
                    rx_valid_o <= 1'b1;
                    @(posedge clk_i);
                end
                // Released byte lane shows no stale value
                rx_valid_o <= 1'b0;
                rx_data_o <= ~cmd_i[31:24];
                tx_ready_o <= 1'b1;
                w = 0;
                while (count_o < 28 && w < 200) begin
                    @(posedge clk_i);
                    w++;
                    if (tx_valid_i === 1'b1 && tx_ready_o === 1'b1) begin
                        reply_q[count_o] = tx_data_i;
                        count_o = count_o + 1;
                    end
                    tx_ready_o <= stall_i ? ~tx_ready_o : 1'b1;
                end
                tx_ready_o <= 1'b0;
                done_o <= 1'b1;
            end
        end
    end
endmodule

// ### tb/tb_protection_and_trigger_settings_readout.sv
`timescale 1ns/1ps
module tb_protection_and_trigger_settings_readout;
    import ptsr_pkg::*;

    logic clk_i, srst_i, wr_i, rd_i, tx_valid_o, tx_ready_i, rx_valid_i, stop_i;
    logic [7:0] addr_i, rx_data_i, tx_data_o;
    logic [31:0] wdata_i, rdata_o, cmd;
    ptsr_meas_t meas_i;
    ptsr_fault_t fault_i;
    logic trig_pin_i, stepper_i, go, stall, done;
    logic [2:0] step_division_setting_i;
    logic alarm_o, motor_off_o, power_off_o, link_recovery_enable_o, move_start_o;
    ptsr_move_t move_o;
    int count, ix, bad_count = 0, checks = 0, moves = 0;
    logic [7:0] exp_b [28];
    ptsr_fault_t fv [4] = '{5'h10, 5'h04, 5'h02, 5'h01};
    logic [7:0] fb [4] = '{8'h01, 8'h08, 8'h40, 8'h80};

    ptsr_top #(.CYC_PER_US(2)) ptsr_top_inst (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_data_i(rx_data_i),
        .rx_valid_i(rx_valid_i), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o),
        .tx_ready_i(tx_ready_i), .meas_i(meas_i), .fault_i(fault_i), .stop_i(stop_i),
        .trig_pin_i(trig_pin_i), .stepper_i(stepper_i),
        .step_division_setting_i(step_division_setting_i), .alarm_o(alarm_o),
        .motor_off_o(motor_off_o), .power_off_o(power_off_o),
        .link_recovery_enable_o(link_recovery_enable_o), .move_start_o(move_start_o),
        .move_o(move_o));

    ptsr_host_model ptsr_host_model_inst (.clk_i(clk_i), .go_i(go), .cmd_i(cmd),
        .stall_i(stall), .tx_data_i(tx_data_o), .tx_valid_i(tx_valid_o), .rx_data_o(rx_data_i),
        .rx_valid_o(rx_valid_i), .tx_ready_o(tx_ready_i), .done_o(done), .count_o(count));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) if (move_start_o === 1'b1) moves++;

    // ************************************************
    // Tasks
    // ************************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk("read data", exp, rdata_o);
        @(posedge clk_i);
    endtask

    task automatic xfer(input logic [31:0] c, input logic s);
        @(posedge clk_i);
        cmd <= c;
        stall <= s;
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        @(posedge clk_i);
        for (int i = 0; i < 400 && done !== 1'b1; i++) @(posedge clk_i);
    endtask

    task automatic put(input logic [7:0] b);
        exp_b[ix] = b;
        ix++;
    endtask

    task automatic put16(input logic [15:0] v);
        put(v[7:0]);
        put(v[15:8]);
    endtask

    task automatic put32(input logic [31:0] v);
        put16(v[15:0]);
        put16(v[31:16]);
    endtask

    // Appends the expected checksum, then compares the captured frame
    task automatic check_reply();
        logic [15:0] c;
        c = CRC_INIT;
        for (int i = 0; i < BODY_BYTES; i++) begin
            c = c ^ {8'h00, exp_b[i]};
            for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        put16(c);
        chk("reply length", FRAME_BYTES, count);
        for (int i = 0; i < FRAME_BYTES; i++)
            chk("reply byte", {24'h0, exp_b[i]}, {24'h0, ptsr_host_model_inst.reply_q[i]});
        chk("reply end", 32'h0, {31'h0, tx_valid_o});
    endtask

    task automatic chk_move(input logic ab, input logic [15:0] f, input logic [7:0] fs);
        chk("move absolute", {31'h0, ab}, {31'h0, move_o.absolute});
        chk("move position", 32'hFFFFFF9C, move_o.pos);
        chk("move fine", {16'h0, f}, {16'h0, move_o.fine});
        chk("move speed", 32'h000186A0, move_o.speed);
        chk("move fine speed", {24'h0, fs}, {24'h0, move_o.fine_speed});
    endtask

    task automatic pin(input logic v, input int n);
        trig_pin_i <= v;
        wait_n(n);
    endtask

    task automatic flag_out(input string what, input logic exp, input logic got);
        chk(what, {31'h0, exp}, {31'h0, got});
    endtask

    // ************************************************
    // Sequence
    // ************************************************
    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        final_report();
    end

    initial begin
        {srst_i, wr_i, rd_i, stop_i, trig_pin_i, go, stall} = 7'h41;
        {addr_i, wdata_i, cmd} = '0;
        meas_i = '0;
        fault_i = '0;
        stepper_i = 1'b1;
        step_division_setting_i = 3'h3;
        wait_n(8);
        srst_i <= 1'b0;
        reg_chk(A_LIMIT0 + 8'h04, 32'h0000FFFF);
        reg_chk(A_LIMIT6, 32'h00000000);
        reg_chk(8'h3C, 32'h00000000);
        ix = 0;
        put32(CMD_PROT);
        for (int i = 0; i < LIM_N; i++) begin
            reg_wr(A_LIMIT0 + 8'(4 * i), {16'h0, 16'h1357 + 16'(i * 257)});
            put16(16'h1357 + 16'(i * 257));
        end
        reg_wr(A_PFLAGS, 32'h000000A5);
        put(8'hA5);
        repeat (7) put(8'h00);
        xfer(CMD_PROT, 1'b0);
        check_reply();
        flag_out("link recovery", 1'b1, link_recovery_enable_o);
        reg_wr(A_TFLAGS, 32'h00000007);
        reg_wr(A_DEAD, 32'h0000000A);
        reg_wr(A_POS, 32'hFFFFFF9C);
        reg_wr(A_FPOS, 32'h0000FFFD);
        reg_wr(A_SPEED, 32'h000186A0);
        reg_wr(A_FSPEED, 32'h00000005);
        ix = 0;
        put32(CMD_TRIG);
        put(8'h07);
        put16(16'h000A);
        put32(32'hFFFFFF9C);
        put16(16'hFFFD);
        put32(32'h000186A0);
        put(8'h05);
        repeat (8) put(8'h00);
        xfer(CMD_TRIG, 1'b1);
        check_reply();
        reg_wr(A_PFLAGS, 32'h00000000);
        wait_n(3);
        flag_out("link recovery", 1'b0, link_recovery_enable_o);
        reg_wr(A_LIMIT0, 32'h00000200);
        reg_wr(A_LIMIT6, 32'h000001F4);
        reg_wr(A_LIMIT0 + 8'h04, 32'h00000100);
        meas_i <= '{16'h01FF, 16'h0100, 16'h0000, 16'h0000, 16'h01F4};
        wait_n(3);
        flag_out("alarm at limit", 1'b0, alarm_o);
        flag_out("motor off unflagged", 1'b0, motor_off_o);
        meas_i.pwr_i <= 16'h0101;
        wait_n(3);
        flag_out("alarm over current", 1'b1, alarm_o);
        meas_i.pwr_i <= 16'h0000;
        meas_i.usb_v <= 16'h01F3;
        wait_n(3);
        flag_out("alarm usb low", 1'b1, alarm_o);
        meas_i.usb_v <= 16'h01F4;
        reg_wr(A_LIMIT0 + 8'h08, 32'h000001FE);
        wait_n(3);
        flag_out("alarm over voltage", 1'b1, alarm_o);
        reg_wr(A_LIMIT0 + 8'h08, 32'h0000FFFF);
        reg_wr(A_PFLAGS, 32'h00000002);
        wait_n(3);
        flag_out("alarm cleared", 1'b0, alarm_o);
        flag_out("motor off", 1'b1, motor_off_o);
        meas_i.pwr_v <= 16'h0200;
        for (int i = 0; i < 4; i++) begin
            reg_wr(A_PFLAGS, 32'h00000000);
            fault_i <= fv[i];
            wait_n(4);
            flag_out("alarm unflagged", 1'b0, alarm_o);
            reg_wr(A_PFLAGS, {24'h0, fb[i]});
            wait_n(3);
            flag_out("alarm flagged", 1'b1, alarm_o);
            fault_i <= '0;
            wait_n(3);
            flag_out("alarm released", 1'b0, alarm_o);
        end
        reg_wr(A_PFLAGS, 32'h00000000);
        fault_i <= 5'h08;
        wait_n(4);
        flag_out("power off unflagged", 1'b0, power_off_o);
        reg_wr(A_PFLAGS, 32'h00000004);
        wait_n(3);
        flag_out("power off", 1'b1, power_off_o);
        reg_wr(A_PFLAGS, 32'h00000011);
        fault_i <= 5'h10;
        wait_n(3);
        fault_i <= '0;
        wait_n(6);
        flag_out("alarm latched", 1'b1, alarm_o);
        stop_i <= 1'b1;
        wait_n(1);
        stop_i <= 1'b0;
        wait_n(3);
        flag_out("alarm after stop", 1'b0, alarm_o);
        reg_wr(A_PFLAGS, 32'h00000000);
        xfer(32'h12345678, 1'b0);
        chk("unknown reply length", 32'h0, count);
        reg_chk(A_STATUS, 32'h00000008);
        reg_wr(A_STATUS, 32'h00000008);
        reg_chk(A_STATUS, 32'h00000000);
        reg_wr(A_TFLAGS, 32'h00000000);
        pin(1'b1, 40);
        pin(1'b0, 40);
        chk("moves disabled", 32'h0, moves);
        reg_wr(A_TFLAGS, 32'h00000005);
        pin(1'b1, 40);
        chk("moves rising", 32'h1, moves);
        chk_move(1'b1, 16'hFFFD, 8'h05);
        pin(1'b0, 40);
        pin(1'b1, 6);
        pin(1'b0, 6);
        pin(1'b1, 40);
        chk("moves dead time", 32'h2, moves);
        pin(1'b0, 40);
        reg_wr(A_TFLAGS, 32'h00000003);
        stepper_i <= 1'b0;
        pin(1'b1, 40);
        chk("moves falling only", 32'h2, moves);
        pin(1'b0, 40);
        chk("moves falling", 32'h3, moves);
        chk_move(1'b0, 16'h0000, 8'h00);
        final_report();
    end
endmodule
